// >>> verilog/mfmc_top.sv
// Memory fetch mode configuration: data map select and ROM fetch speed register.
`timescale 1ns/10ps
`default_nettype none
`include "mfmc_map.svh"
// Contract
// RL1 - The CPU address space spans one megabyte, twenty address bits.
// RL2 - The data area page follows the operand of the map select instruction.
// RL3 - Software runs the map select instruction once after reset, never again.
// RL4 - Startup runs map select with 0H or 0FH, loads stack, then fetch speed.
// RL5 - Reset loads the fetch speed register with 20H, low-speed fetch.
// RL6 - Software writes 80H to the fetch speed register after reset.
// RL7 - The fetch speed register is accessed only with byte-wide accesses.
// RL8 - Bit 7 selects fast fetch, bit 5 slow fetch; other bits are zero.
// RL9 - Slow setting fetches one byte from internal ROM every six cycles.
// RL10 - Fast setting fetches two bytes from internal ROM every two cycles.
// RL11 - After reset the CPU uses the external-ROM-like fetch cycle.
// RL12 - Software never writes both select bits equal; behaviour is undefined.
// RL13 - Fixed-zero bits read as zero and ignore writes.
module mfmc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`MFMC_ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_byte,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  input wire logic map_sel_valid,
  input wire logic [3:0] map_sel_operand,
  output logic map_locked,
  output mfmc_pkg::mfmc_page_t data_page,
  input wire logic fetch_en,
  output logic fetch_strobe,
  output logic fetch_two_bytes,
  output logic fetch_fast
);
  import mfmc_pkg::*;

  logic [7:0] rom_fetch_speed_control;
  logic reg_hit;
  logic op_valid;
  mfmc_fetch_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // The register lives in whichever 64 KB page the data area was mapped to.
  assign reg_hit = (mem_addr[15:0] == `MFMC_FSC_OFFSET) &&
                   (mem_addr[`MFMC_ADDR_W-1:16] == data_page); // RL1 RL2
  assign op_valid = (map_sel_operand == `MFMC_PAGE_LOW) ||
                    (map_sel_operand == `MFMC_PAGE_HIGH);

  // Only the first legal map select takes effect; later ones are dropped.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_page <= `MFMC_PAGE_LOW;
      map_locked <= 1'b0;
    end else if (map_sel_valid && !map_locked && op_valid) begin
      data_page <= map_sel_operand; // RL2 RL3
      map_locked <= 1'b1; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word accesses never touch the register, so a stray 16-bit store is harmless.
  always_ff @(posedge clk) begin
    if (rst) begin
      rom_fetch_speed_control <= `MFMC_FSC_RESET; // RL5 RL11
    end else if (mem_wr && mem_byte && reg_hit) begin
      rom_fetch_speed_control <= mem_wdata & `MFMC_FSC_MASK; // RL7 RL8 RL13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rdata <= 8'h00;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= mem_rd && mem_byte && reg_hit; // RL7
      mem_rdata <= (mem_rd && mem_byte && reg_hit) ?
                   (rom_fetch_speed_control & `MFMC_FSC_MASK) : 8'h00; // RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Any setting other than fast-only falls back to the safe slow pace.
  assign mode = (rom_fetch_speed_control[`MFMC_FAST_BIT] &&
                 !rom_fetch_speed_control[`MFMC_SLOW_BIT]) ?
                MFMC_FETCH_FAST : MFMC_FETCH_SLOW; // RL9 RL10 RL12

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_fast <= 1'b0; // RL11
    end else begin
      fetch_fast <= (mode == MFMC_FETCH_FAST);
    end
  end

  mfmc_fetch_pacer u_pacer (
    .clk(clk),
    .rst(rst),
    .mode(mode),
    .fetch_en(fetch_en),
    .fetch_strobe(fetch_strobe),
    .fetch_two_bytes(fetch_two_bytes)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_value_slow: assert property ( // RL5
    $past(rst) |-> rom_fetch_speed_control == 8'h20 && !fetch_fast)
    else $error("fetch speed register not 20H after reset");

  a_byte_write_store: assert property ( // RL7
    mem_wr && mem_byte && reg_hit |=> rom_fetch_speed_control == ($past(mem_wdata) & 8'ha0))
    else $error("byte write to fetch speed register not stored");

  a_word_write_ignored: assert property ( // RL7
    mem_wr && !mem_byte |=> $stable(rom_fetch_speed_control))
    else $error("word write changed fetch speed register");

  a_zero_bits_read: assert property ( // RL13
    mem_rvalid |-> mem_rdata[6] == 1'b0 && mem_rdata[4:0] == 5'h00)
    else $error("fixed-zero bits read nonzero");

  a_read_returns_reg: assert property ( // RL8
    mem_rd && mem_byte && reg_hit && !mem_wr |=> mem_rvalid &&
      mem_rdata == $past(rom_fetch_speed_control))
    else $error("read data does not match register");

  a_map_once_only: assert property ( // RL3
    map_locked |=> map_locked && $stable(data_page))
    else $error("data map changed after first select");

  a_map_select_page: assert property ( // RL2
    map_sel_valid && !map_locked && op_valid |=> map_locked &&
      data_page == $past(map_sel_operand))
    else $error("data map select not applied");

  a_fast_mode_decode: assert property ( // RL10
    rom_fetch_speed_control == 8'h80 |=> fetch_fast)
    else $error("80H setting did not select fast fetch");

  a_slow_mode_decode: assert property ( // RL9
    rom_fetch_speed_control == 8'h20 |=> !fetch_fast)
    else $error("20H setting did not select slow fetch");
endmodule
`default_nettype wire

// >>> verilog/mfmc_map.svh
// Address, field and timing constants of the memory fetch mode configuration block.
`ifndef MFMC_MAP_SVH
`define MFMC_MAP_SVH
`define MFMC_ADDR_W 20
`define MFMC_FSC_OFFSET 16'hffc4
`define MFMC_FSC_RESET 8'h20
`define MFMC_FSC_INIT 8'h80
`define MFMC_FSC_MASK 8'ha0
`define MFMC_FAST_BIT 7
`define MFMC_SLOW_BIT 5
`define MFMC_PAGE_LOW 4'h0
`define MFMC_PAGE_HIGH 4'hf
`define MFMC_SLOW_CYCLES 3'h6
`define MFMC_FAST_CYCLES 3'h2
`endif

// >>> verilog/mfmc_pkg.sv
// Types shared by the memory fetch mode configuration block.
package mfmc_pkg;
  typedef enum logic {
    MFMC_FETCH_SLOW,
    MFMC_FETCH_FAST
  } mfmc_fetch_mode_t;
  typedef logic [3:0] mfmc_page_t;
endpackage

// >>> verilog/mfmc_fetch_pacer.sv
// Internal ROM fetch pacer: issues fetch strobes at the selected fetch speed.
`timescale 1ns/10ps
`default_nettype none
`include "mfmc_map.svh"
module mfmc_fetch_pacer (
  input wire logic clk,
  input wire logic rst,
  input wire mfmc_pkg::mfmc_fetch_mode_t mode,
  input wire logic fetch_en,
  output logic fetch_strobe,
  output logic fetch_two_bytes
);
  import mfmc_pkg::*;

  logic [2:0] cnt;
  logic [2:0] last;

  assign last = (mode == MFMC_FETCH_FAST) ? (`MFMC_FAST_CYCLES - 3'h1)
                                          : (`MFMC_SLOW_CYCLES - 3'h1);

  // A mode change mid-count cannot strand the counter above the new limit.
  always_ff @(posedge clk) begin
    if (rst || !fetch_en) begin
      cnt <= 3'h0;
      fetch_strobe <= 1'b0;
    end else if (cnt >= last) begin
      cnt <= 3'h0;
      fetch_strobe <= 1'b1; // RL9 RL10
    end else begin
      cnt <= cnt + 3'h1;
      fetch_strobe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_two_bytes <= 1'b0;
    end else begin
      fetch_two_bytes <= (mode == MFMC_FETCH_FAST); // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each gap is judged at the next strobe, looking back over the idle cycles before it.
  sequence slow_gap;
    fetch_strobe && !$past(fetch_strobe) && !$past(fetch_strobe, 2) &&
      !$past(fetch_strobe, 3) && !$past(fetch_strobe, 4) && !$past(fetch_strobe, 5);
  endsequence

  sequence fast_gap;
    fetch_strobe && !$past(fetch_strobe);
  endsequence

  a_slow_fetch_spacing: assert property (@(posedge clk) disable iff (rst) // RL9
    (fetch_strobe && fetch_en && mode == MFMC_FETCH_SLOW && cnt == 3'h0)
      ##0 (fetch_en && mode == MFMC_FETCH_SLOW) [*6] |-> ##1 slow_gap)
    else $error("slow fetch strobe spacing is not six cycles");

  a_fast_fetch_spacing: assert property (@(posedge clk) disable iff (rst) // RL10
    (fetch_strobe && fetch_en && mode == MFMC_FETCH_FAST && $past(mode) == MFMC_FETCH_FAST)
      ##0 (fetch_en && mode == MFMC_FETCH_FAST) [*2] |-> ##1 fast_gap)
    else $error("fast fetch strobe spacing is not two cycles");

  a_fast_two_bytes: assert property (@(posedge clk) disable iff (rst) // RL10
    fetch_strobe && $past(mode) == MFMC_FETCH_FAST |-> fetch_two_bytes)
    else $error("fast fetch does not deliver two bytes");
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the memory fetch mode configuration block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst, mem_wr, mem_rd, mem_byte, map_sel_valid, fetch_en;
  logic [19:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [3:0] map_sel_operand;
  logic mem_rvalid, map_locked, fetch_strobe, fetch_two_bytes, fetch_fast;
  mfmc_pkg::mfmc_page_t data_page;
  int errors = 0, n_tests = 0, reg_m = 32, page_m = 0, lock_m = 0, seed = 31;
  mfmc_top dut (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_byte(mem_byte), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .map_sel_valid(map_sel_valid),
    .map_sel_operand(map_sel_operand), .map_locked(map_locked), .data_page(data_page),
    .fetch_en(fetch_en), .fetch_strobe(fetch_strobe),
    .fetch_two_bytes(fetch_two_bytes), .fetch_fast(fetch_fast));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One byte or word access; the model decodes only inside the mapped page.
  task automatic acc(logic wr, logic byt, logic [19:0] a, logic [7:0] d);
    bit hit;
    hit = byt && a[15:0] == 16'hffc4 && a[19:16] == page_m;
    @(posedge clk);
    mem_wr <= wr;
    mem_rd <= !wr;
    mem_byte <= byt;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_wr <= 1'h0;
    mem_rd <= 1'h0;
    #1;
    chk("rvalid", {7'h0, mem_rvalid}, {7'h0, !wr && hit});
    chk("rdata", mem_rdata, (!wr && hit) ? 8'(reg_m) : 8'h00);
    if (wr && hit) reg_m = d & 8'ha0;
  endtask
  task automatic sel(logic [3:0] op);
    @(posedge clk);
    map_sel_valid <= 1'h1;
    map_sel_operand <= op;
    @(posedge clk);
    map_sel_valid <= 1'h0;
    #1;
    if (lock_m == 0 && (op == 4'h0 || op == 4'hf)) begin
      lock_m = 1;
      page_m = op;
    end
    chk("locked", {7'h0, map_locked}, 8'(lock_m));
    chk("page", {4'h0, data_page}, 8'(page_m));
  endtask
  // Restarts the pacer and measures the first two strobe spacings.
  task automatic gap(int exp);
    int n;
    @(posedge clk);
    fetch_en <= 1'h0;
    @(posedge clk);
    fetch_en <= 1'h1;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (fetch_strobe !== 1'h1 && n < 20);
      chk("fetch gap", 8'(n), 8'(exp));
    end
    chk("two bytes", {7'h0, fetch_two_bytes}, 8'(exp == 2));
    chk("fast", {7'h0, fetch_fast}, 8'(exp == 2));
  endtask
  task automatic results();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {mem_wr, mem_rd, mem_byte, map_sel_valid, fetch_en, rst} = 6'h01;
    mem_addr = 20'h0;
    mem_wdata = 8'h0;
    map_sel_operand = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("fast at reset", {7'h0, fetch_fast}, 8'h00);
    sel(4'h0);
    acc(1'h0, 1'h1, 20'h0ffc4, 8'h00);
    gap(6);
    acc(1'h1, 1'h1, 20'h0ffc4, 8'h80);
    acc(1'h1, 1'h0, 20'h0ffc4, 8'h20);
    acc(1'h0, 1'h0, 20'h0ffc4, 8'h00);
    acc(1'h0, 1'h1, 20'h0ffc4, 8'h00);
    acc(1'h1, 1'h1, 20'h0ffc4, 8'h80 | 8'(rnd() & 8'h5f));
    acc(1'h0, 1'h1, 20'h0ffc4, 8'h00);
    gap(2);
    sel(4'hf);
    sel(4'h5);
    acc(1'h0, 1'h1, 20'hfffc4, 8'h00);
    // A second reset must unlock the map so the high page can be chosen.
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    reg_m = 32;
    page_m = 0;
    lock_m = 0;
    #1;
    chk("locked after reset", {7'h0, map_locked}, 8'h00);
    chk("fast after reset", {7'h0, fetch_fast}, 8'h00);
    sel(4'hf);
    sel(4'h0);
    acc(1'h0, 1'h1, 20'h0ffc4, 8'h00);
    acc(1'h0, 1'h1, 20'hfffc4, 8'h00);
    acc(1'h1, 1'h1, 20'hfffc4, 8'h80);
    acc(1'h1, 1'h1, 20'hfffc4, 8'h20 | 8'(rnd() & 8'h5f));
    acc(1'h0, 1'h1, 20'hfffc4, 8'h00);
    gap(6);
    repeat (20) acc(1'(rnd()), 1'(rnd()), 20'(rnd()), 8'(rnd()));
    results();
  end
  initial begin
    #20000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
